// ### core/bclc_defines.svh
`ifndef BCLC_DEFINES_SVH
`define BCLC_DEFINES_SVH

// ----------------------------------------------------------------------------
// Register indices on the plain register port
// ----------------------------------------------------------------------------
`define BCLC_ADDR_W          2
`define BCLC_IDX_CONTROL     2'h0
`define BCLC_IDX_TUNING      2'h1
`define BCLC_IDX_LOCK        2'h2
`define BCLC_IDX_MISS        2'h3

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define BCLC_RST_CONTROL     8'hE6
`define BCLC_RST_TUNING      8'h00
`define BCLC_RST_SLOT_PTR    5'h1F
`define BCLC_RST_MISS        12'h000

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define BCLC_CTL_WREN_BIT    7
`define BCLC_CTL_FLUSH_BIT   4
`define BCLC_LCK_PUSH_BIT    7
`define BCLC_LCK_POP_BIT     6
`define BCLC_MISS_OV_BIT     7

// ----------------------------------------------------------------------------
// Lock limits and counter geometry
// ----------------------------------------------------------------------------
`define BCLC_MAX_LOCKED      30
`define BCLC_POP_AVOID_PTR   5'h1E
`define BCLC_ALL_UNLOCK_PTR  5'h00
`define BCLC_MISS_CNT_W      12

`endif

// ### core/bclc_pkg.sv
package bclc_pkg;

    // ------------------------------------------------------------------------
    // Shared types
    // ------------------------------------------------------------------------
    typedef logic [4:0]  bclc_slot_t;
    typedef logic [12:0] bclc_tag_t;
    typedef logic [31:0] bclc_word_t;

    // One code segment travelling toward the slot store.
    typedef struct packed {
        logic       valid;
        bclc_slot_t slot;
        bclc_tag_t  tag;
        bclc_word_t data;
    } bclc_fill_s;

    // One table read from the core with its aligned four-byte segment.
    typedef struct packed {
        logic       valid;
        bclc_tag_t  tag;
        bclc_word_t data;
    } bclc_movc_s;

endpackage : bclc_pkg

// ### core/bclc_slot_mem.sv
`timescale 1ns/1ns
`default_nettype none

module bclc_slot_mem #(
    parameter int ENTRIES = 32,
    parameter int TAG_W   = 13,
    parameter int DATA_W  = 32
) (
    input  wire logic                       sys_clk,
    input  wire logic                       reset_n,
    input  wire logic                       wr_en,
    input  wire logic [$clog2(ENTRIES)-1:0] wr_idx,
    input  wire logic [TAG_W-1:0]           wr_tag,
    input  wire logic [DATA_W-1:0]          wr_data,
    input  wire logic                       clr_all,
    input  wire logic [$clog2(ENTRIES)-1:0] rd_idx,
    output logic                            rd_valid,
    output logic [TAG_W-1:0]                rd_tag,
    output logic [DATA_W-1:0]               rd_data
);

    logic [ENTRIES-1:0] valid_reg;
    logic [ENTRIES-1:0] valid_next;
    logic [TAG_W-1:0]   tag_mem  [ENTRIES];
    logic [DATA_W-1:0]  data_mem [ENTRIES];

    // Flush clears every valid bit; a write in the same cycle still lands.
    always_comb begin
        valid_next = clr_all ? '0 : valid_reg;
        if (wr_en) begin
            valid_next[wr_idx] = 1'b1;
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            valid_reg <= '0;
        end else begin
            valid_reg <= valid_next;
        end
    end

    // Tag and data need no reset; the valid bit guards them.
    always_ff @(posedge sys_clk) begin
        if (wr_en) begin
            tag_mem[wr_idx]  <= wr_tag;
            data_mem[wr_idx] <= wr_data;
        end
        rd_tag  <= tag_mem[rd_idx];
        rd_data <= data_mem[rd_idx];
    end

    // Read valid follows the registered data with the same one-cycle latency.
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            rd_valid <= 1'b0;
        end else begin
            rd_valid <= valid_reg[rd_idx];
        end
    end

endmodule : bclc_slot_mem

`default_nettype wire

// ### core/bclc_top.sv
// The placing of the registers and the strobed register port were left to the implementer.
`timescale 1ns/1ns
`default_nettype none
`include "bclc_defines.svh"

module bclc_top #(
    parameter int SLOTS = 32
) (
    input  wire logic                     sys_clk,
    input  wire logic                     reset_n,
    input  wire logic [`BCLC_ADDR_W-1:0]  reg_addr,
    input  wire logic [7:0]               reg_wdata,
    input  wire logic                     reg_wr,
    input  wire logic                     reg_rd,
    output logic [7:0]                    reg_rdata,
    input  wire bclc_pkg::bclc_movc_s     movc_in,
    input  wire bclc_pkg::bclc_fill_s     repl_in,
    input  wire logic                     miss_stall,
    input  wire bclc_pkg::bclc_slot_t     lookup_slot,
    output logic                          lookup_valid,
    output bclc_pkg::bclc_tag_t           lookup_tag,
    output bclc_pkg::bclc_word_t          lookup_data,
    output logic                          repl_refused,
    output bclc_pkg::bclc_slot_t          lock_slot_pointer
);

    // ------------------------------------------------------------------------
    // Elaboration check
    // ------------------------------------------------------------------------
    if (SLOTS != 32) begin : g_slots_chk
        $error("bclc_top supports exactly 32 slots with a five-bit pointer");
    end

    // ------------------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------------------
    logic [7:0]                    control_reg;
    logic [7:0]                    control_next;
    logic [7:0]                    tuning_reg;
    logic [7:0]                    tuning_next;
    logic                          lock_push_enable_reg;
    logic                          lock_push_enable_next;
    bclc_pkg::bclc_slot_t          slot_ptr_reg;
    bclc_pkg::bclc_slot_t          slot_ptr_next;
    logic [`BCLC_MISS_CNT_W-1:0]   miss_cnt_reg;
    logic [`BCLC_MISS_CNT_W-1:0]   miss_cnt_next;
    logic                          miss_penalty_overflow_reg;
    logic                          miss_penalty_overflow_next;
    logic                          flush_pend_reg;
    logic                          flush_pend_next;
    logic [7:0]                    rdata_reg;
    logic [7:0]                    rdata_next;
    logic                          refused_reg;
    logic                          refused_next;

    logic                          wr_ctl;
    logic                          wr_lock;
    logic                          wr_miss;
    logic                          rd_miss;
    logic                          cache_invalidate_strobe;
    logic                          lock_pop_strobe;
    logic                          push_now;
    logic                          repl_locked;
    logic                          repl_write;
    logic                          miss_wrap;
    bclc_pkg::bclc_fill_s          mem_wr;

    // ------------------------------------------------------------------------
    // Register port decode
    // ------------------------------------------------------------------------
    assign wr_ctl  = reg_wr && (reg_addr == `BCLC_IDX_CONTROL);
    assign wr_lock = reg_wr && (reg_addr == `BCLC_IDX_LOCK);
    assign wr_miss = reg_wr && (reg_addr == `BCLC_IDX_MISS);
    assign rd_miss = reg_rd && (reg_addr == `BCLC_IDX_MISS);
    assign cache_invalidate_strobe = wr_ctl && reg_wdata[`BCLC_CTL_FLUSH_BIT];
    assign lock_pop_strobe         = wr_lock && reg_wdata[`BCLC_LCK_POP_BIT];

    // ------------------------------------------------------------------------
    // Lock window and slot writes
    // ------------------------------------------------------------------------
    // A replacement slot is locked only when it sits above the pointer, and a
    // pointer at zero means the lock window has run out so nothing is locked.
    assign repl_locked = (slot_ptr_reg != `BCLC_ALL_UNLOCK_PTR)
                         && (repl_in.slot > slot_ptr_reg);
    assign push_now    = lock_push_enable_reg && movc_in.valid;
    // Normal fills also need the write-enable bit; pushes ignore it.
    assign repl_write  = repl_in.valid && !repl_locked && !push_now
                         && control_reg[`BCLC_CTL_WREN_BIT];

    // Push has priority over a replacement fill in the same cycle.
    always_comb begin
        mem_wr = '0;
        if (push_now) begin
            mem_wr.valid = 1'b1;
            mem_wr.slot  = slot_ptr_reg;
            mem_wr.tag   = movc_in.tag;
            mem_wr.data  = movc_in.data;
        end else if (repl_write) begin
            mem_wr = repl_in;
        end
    end

    // ------------------------------------------------------------------------
    // Lock control: push enable and slot pointer
    // ------------------------------------------------------------------------
    // The pointer is read-only on the port. Push and pop in one cycle cancel.
    // Pop changes only the pointer and never touches the slot store.
    always_comb begin
        lock_push_enable_next = lock_push_enable_reg;
        slot_ptr_next         = slot_ptr_reg;
        if (wr_lock) begin
            lock_push_enable_next = reg_wdata[`BCLC_LCK_PUSH_BIT];
        end
        if (push_now && !lock_pop_strobe) begin
            slot_ptr_next = slot_ptr_reg - 5'h01;
        end else if (lock_pop_strobe && !push_now) begin
            slot_ptr_next = slot_ptr_reg + 5'h01;
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            lock_push_enable_reg <= 1'b0;
            slot_ptr_reg         <= `BCLC_RST_SLOT_PTR;
        end else begin
            lock_push_enable_reg <= lock_push_enable_next;
            slot_ptr_reg         <= slot_ptr_next;
        end
    end

    // ------------------------------------------------------------------------
    // Control, tuning and flush
    // ------------------------------------------------------------------------
    // The flush bit is never stored; it arms a one-cycle invalidate.
    always_comb begin
        control_next    = control_reg;
        tuning_next     = tuning_reg;
        flush_pend_next = cache_invalidate_strobe;
        if (wr_ctl) begin
            control_next = reg_wdata;
            control_next[`BCLC_CTL_FLUSH_BIT] = 1'b0;
        end
        if (reg_wr && (reg_addr == `BCLC_IDX_TUNING)) begin
            tuning_next[3:0] = reg_wdata[3:0];
        end
        if (rd_miss) begin
            tuning_next[7:4] = miss_cnt_reg[4:1];
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            control_reg    <= `BCLC_RST_CONTROL;
            tuning_reg     <= `BCLC_RST_TUNING;
            flush_pend_reg <= 1'b0;
        end else begin
            control_reg    <= control_next;
            tuning_reg     <= tuning_next;
            flush_pend_reg <= flush_pend_next;
        end
    end

    // ------------------------------------------------------------------------
    // Miss penalty accumulator
    // ------------------------------------------------------------------------
    // A wrap in the same cycle as a write keeps the flag set, so no event is
    // lost to the clear.
    assign miss_wrap = miss_stall && (miss_cnt_reg == '1);

    always_comb begin
        miss_cnt_next              = miss_cnt_reg;
        miss_penalty_overflow_next = miss_penalty_overflow_reg;
        if (wr_miss) begin
            miss_cnt_next              = {reg_wdata[6:0], 5'h00};
            miss_penalty_overflow_next = 1'b0;
        end else if (miss_stall) begin
            miss_cnt_next = miss_cnt_reg + 12'h001;
        end
        if (miss_wrap) begin
            miss_penalty_overflow_next = 1'b1;
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            miss_cnt_reg              <= `BCLC_RST_MISS;
            miss_penalty_overflow_reg <= 1'b0;
        end else begin
            miss_cnt_reg              <= miss_cnt_next;
            miss_penalty_overflow_reg <= miss_penalty_overflow_next;
        end
    end

    // ------------------------------------------------------------------------
    // Read data and status outputs
    // ------------------------------------------------------------------------
    // Strobe bits read zero; reserved lock bit 5 reads zero.
    always_comb begin
        rdata_next   = 8'h00;
        refused_next = repl_in.valid && repl_locked;
        if (reg_rd) begin
            case (reg_addr)
                `BCLC_IDX_CONTROL: rdata_next = control_reg;
                `BCLC_IDX_TUNING:  rdata_next = tuning_reg;
                `BCLC_IDX_LOCK:    rdata_next = {lock_push_enable_reg, 2'b00,
                                                 slot_ptr_reg};
                `BCLC_IDX_MISS:    rdata_next = {miss_penalty_overflow_reg,
                                                 miss_cnt_reg[11:5]};
                default:           rdata_next = 8'h00;
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            rdata_reg   <= 8'h00;
            refused_reg <= 1'b0;
        end else begin
            rdata_reg   <= rdata_next;
            refused_reg <= refused_next;
        end
    end

    assign reg_rdata         = rdata_reg;
    assign repl_refused      = refused_reg;
    assign lock_slot_pointer = slot_ptr_reg;

    // ------------------------------------------------------------------------
    // Slot store
    // ------------------------------------------------------------------------
    bclc_slot_mem #(
        .ENTRIES (SLOTS),
        .TAG_W   (13),
        .DATA_W  (32)
    ) u_slot_mem (
        .sys_clk  (sys_clk),
        .reset_n  (reset_n),
        .wr_en    (mem_wr.valid),
        .wr_idx   (mem_wr.slot),
        .wr_tag   (mem_wr.tag),
        .wr_data  (mem_wr.data),
        .clr_all  (flush_pend_reg),
        .rd_idx   (lookup_slot),
        .rd_valid (lookup_valid),
        .rd_tag   (lookup_tag),
        .rd_data  (lookup_data)
    );

    // ------------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------------
    lock_window_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
        (repl_in.slot <= 5'h01) |-> !repl_locked)
        else $error("Slot zero or one reported as locked.");

    push_store_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
        push_now |-> mem_wr.valid && mem_wr.slot == slot_ptr_reg && mem_wr.data == movc_in.data)
        else $error("Push did not write the pointed slot.");

    push_dec_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
        (push_now && !lock_pop_strobe) |=> slot_ptr_reg == $past(slot_ptr_reg) - 5'h01)
        else $error("Pointer not decremented after push.");

    locked_safe_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
        (mem_wr.valid && !push_now && slot_ptr_reg != 5'h00) |-> mem_wr.slot <= slot_ptr_reg)
        else $error("Replacement wrote a locked slot.");

    pop_inc_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
        (lock_pop_strobe && !push_now) |=> slot_ptr_reg == $past(slot_ptr_reg) + 5'h01)
        else $error("Pointer not incremented after pop.");

    pop_reads_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
        (reg_rd && reg_addr == `BCLC_IDX_LOCK) |=> reg_rdata[6:5] == 2'b00)
        else $error("Pop bit did not read zero.");

    pop_keep_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
        (lock_pop_strobe && !push_now && !repl_write) |-> !mem_wr.valid)
        else $error("Pop disturbed the slot store.");

    zero_unlock_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
        (slot_ptr_reg == 5'h00) |-> !repl_locked)
        else $error("Slot locked with pointer at zero.");

    ov_hold_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
        (miss_penalty_overflow_reg && !wr_miss) |=> miss_penalty_overflow_reg)
        else $error("Overflow flag dropped without a write.");

    ov_set_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
        miss_wrap |=> miss_penalty_overflow_reg
                      && (miss_cnt_reg == 12'h000 || $past(wr_miss)))
        else $error("Wrap did not set the overflow flag.");

    miss_latch_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
        rd_miss |=> tuning_reg[7:4] == $past(miss_cnt_reg[4:1])
                    && reg_rdata[6:0] == $past(miss_cnt_reg[11:5]))
        else $error("Low bits not latched on high read.");

    flush_next_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
        cache_invalidate_strobe |=> flush_pend_reg ##1 1'b1 ##1
        (!lookup_valid || $past(mem_wr.valid, 2)))
        else $error("Flush did not invalidate slots.");

endmodule : bclc_top

`default_nettype wire

// ### sim/bclc_core_model.sv
`timescale 1ns/1ns
`default_nettype none

// ----------------------------------------------------------------------------
// Core side: table reads, replacement fills and miss stalls
// ----------------------------------------------------------------------------
module bclc_core_model (
    input  wire logic            sys_clk,
    output bclc_pkg::bclc_movc_s movc_in,
    output bclc_pkg::bclc_fill_s repl_in,
    output logic                 miss_stall
);
    // Idle lines start low; released fields later carry inverted junk.
    initial begin
        movc_in = '0;
        repl_in = '0;
        miss_stall = 1'b0;
    end

    // One table read handing over its aligned four-byte segment.
    task automatic movc(input bclc_pkg::bclc_tag_t t, input bclc_pkg::bclc_word_t d);
        @(posedge sys_clk);
        movc_in <= {1'b1, t, d};
        @(posedge sys_clk);
        movc_in <= {1'b0, ~t, ~d};
    endtask : movc

    // One normal fill; the tag is taken from the low data bits.
    task automatic repl(input bclc_pkg::bclc_slot_t s, input bclc_pkg::bclc_word_t d);
        @(posedge sys_clk);
        repl_in <= {1'b1, s, d[12:0], d};
        @(posedge sys_clk);
        repl_in <= {1'b0, ~s, ~d[12:0], ~d};
    endtask : repl

    // Stall for exactly n cycles.
    task automatic stall(input int n);
        @(posedge sys_clk);
        miss_stall <= 1'b1;
        repeat (n) @(posedge sys_clk);
        miss_stall <= 1'b0;
    endtask : stall
endmodule : bclc_core_model

`default_nettype wire

// ### sim/tb_branch_cache_lock_control.sv
`timescale 1ns/1ns
`default_nettype none

module tb_branch_cache_lock_control;
    logic                 sys_clk = 1'b0;
    logic                 reset_n = 1'b0;
    logic [1:0]           reg_addr = 2'h0;
    logic [7:0]           reg_wdata = 8'h00;
    logic                 reg_wr = 1'b0;
    logic                 reg_rd = 1'b0;
    logic [7:0]           reg_rdata;
    bclc_pkg::bclc_movc_s movc_in;
    bclc_pkg::bclc_fill_s repl_in;
    logic                 miss_stall;
    bclc_pkg::bclc_slot_t lookup_slot = 5'h00;
    logic                 lookup_valid;
    bclc_pkg::bclc_tag_t  lookup_tag;
    bclc_pkg::bclc_word_t lookup_data;
    logic                 repl_refused;
    bclc_pkg::bclc_slot_t lock_slot_pointer;
    logic [7:0]           v;
    int                   fails = 0;
    int                   checks = 0;
    int                   cycles = 0;
    // Reset values of the four registers, index beside expected byte.
    logic [9:0]           rows [4] = '{10'h0E6, 10'h100, 10'h21F, 10'h300};

    // ------------------------------------------------------------------------
    // Design, core model and clock
    // ------------------------------------------------------------------------
    bclc_top bclc_top_inst (.sys_clk(sys_clk), .reset_n(reset_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .movc_in(movc_in), .repl_in(repl_in), .miss_stall(miss_stall),
        .lookup_slot(lookup_slot), .lookup_valid(lookup_valid), .lookup_tag(lookup_tag),
        .lookup_data(lookup_data), .repl_refused(repl_refused),
        .lock_slot_pointer(lock_slot_pointer));
    bclc_core_model bclc_core_model_inst (.sys_clk(sys_clk), .movc_in(movc_in),
        .repl_in(repl_in), .miss_stall(miss_stall));
    // Half period of 10 ns gives 50 MHz.
    always #10 sys_clk = ~sys_clk;

    // A hang is cut short well above the couple of hundred cycles the run needs.
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            fails++;
            wrap_up();
        end
    end

    // ------------------------------------------------------------------------
    // Bus and compare tasks
    // ------------------------------------------------------------------------
    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask : wr

    // Read data stand only in the cycle after the strobe, so sample just then.
    task automatic rd(input logic [1:0] a, output logic [7:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask : rd

    task automatic look(input bclc_pkg::bclc_slot_t s);
        @(posedge sys_clk);
        lookup_slot <= s;
        @(posedge sys_clk);
        #1;
    endtask : look

    task automatic chk_byte(input string n, input logic [7:0] e, input logic [7:0] g);
        checks++;
        if (g !== e) begin
            fails++;
            $display("wrong value %s exp %h got %h", n, e, g);
        end
    endtask : chk_byte

    task automatic chk_word(input string n, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e) begin
            fails++;
            $display("wrong value %s exp %h got %h", n, e, g);
        end
    endtask : chk_word

    task automatic wrap_up();
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : wrap_up

    // ------------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------------
    initial begin
        repeat (3) @(posedge sys_clk);
        chk_byte("ptr in reset", 8'h1F, {3'h0, lock_slot_pointer});
        repeat (3) @(posedge sys_clk);
        reset_n <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            rd(rows[i][9:8], v);
            chk_byte("reset value", rows[i][7:0], v);
        end
        $display("test reset done");
        // Two pushes lock slots 1F and 1E.
        wr(2'h2, 8'h80);
        bclc_core_model_inst.movc(13'h0101, 32'hA5A50001);
        bclc_core_model_inst.movc(13'h0202, 32'h5A5A0002);
        rd(2'h2, v);
        chk_byte("lock after push", 8'h9D, v);
        bclc_core_model_inst.repl(5'h1F, 32'h00001111);
        #1 chk_word("refused locked", 1, repl_refused);
        look(5'h1F);
        chk_word("slot 1F data", 32'hA5A50001, lookup_data);
        chk_word("slot 1F tag", 32'h0101, lookup_tag);
        bclc_core_model_inst.repl(5'h1D, 32'h00003333);
        #1 chk_word("refused free", 0, repl_refused);
        look(5'h1D);
        chk_word("slot 1D data", 32'h00003333, lookup_data);
        $display("test push done");
        // Pop from 1D only; popping at 1E is avoided.
        wr(2'h2, 8'hC0);
        rd(2'h2, v);
        chk_byte("lock after pop", 8'h9E, v);
        look(5'h1E);
        chk_word("popped valid", 1, lookup_valid);
        chk_word("popped data", 32'h5A5A0002, lookup_data);
        // Thirty pushes drive the pointer to 0, where nothing is locked.
        for (int i = 0; i < 30; i++) bclc_core_model_inst.movc(13'h0, 32'hC0DE0000 + i);
        #1 chk_byte("ptr at zero", 8'h00, {3'h0, lock_slot_pointer});
        bclc_core_model_inst.repl(5'h01, 32'h00004444);
        #1 chk_word("refused at zero", 0, repl_refused);
        wr(2'h2, 8'hC0);
        bclc_core_model_inst.repl(5'h1F, 32'h00005555);
        #1 chk_word("refused at one", 1, repl_refused);
        wr(2'h2, 8'h00);
        bclc_core_model_inst.movc(13'h0303, 32'h77770003);
        #1 chk_byte("ptr push off", 8'h01, {3'h0, lock_slot_pointer});
        $display("test pop done");
        // Flush clears every valid bit and reads zero.
        wr(2'h0, 8'hF6);
        rd(2'h0, v);
        chk_byte("control flush", 8'hE6, v);
        look(5'h1F);
        chk_word("flushed valid", 0, lookup_valid);
        $display("test flush done");
        // 37 stall cycles give high field 01 and low bits 4-1 of 2.
        wr(2'h3, 8'h00);
        bclc_core_model_inst.stall(37);
        rd(2'h3, v);
        chk_byte("miss high", 8'h01, v);
        rd(2'h1, v);
        chk_byte("miss low", 8'h20, v);
        // Preload FE0; 32 more stalls wrap the counter.
        wr(2'h3, 8'h7F);
        bclc_core_model_inst.stall(32);
        rd(2'h3, v);
        chk_byte("miss wrap", 8'h80, v);
        wr(2'h3, 8'h00);
        rd(2'h3, v);
        chk_byte("miss cleared", 8'h00, v);
        $display("test miss done");
        // Write enable off blocks normal fills; tuning top bits ignore writes.
        wr(2'h0, 8'h66);
        bclc_core_model_inst.repl(5'h00, 32'h00006666);
        #1 chk_word("refused wren off", 0, repl_refused);
        look(5'h00);
        chk_word("wren off valid", 0, lookup_valid);
        wr(2'h1, 8'hFF);
        rd(2'h1, v);
        chk_byte("tuning write", 8'h0F, v);
        $display("test tuning done");
        wrap_up();
    end
endmodule : tb_branch_cache_lock_control

`default_nettype wire
